//--- pkg/eeprom_port_pkg.sv
// Constants for the serial EEPROM port
package eeprom_port_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int REF_CLK_MHZ     = 250;
	localparam int MASTER_CLK_MHZ  = 40;
	localparam int SCK_DIVIDER     = 512;
	// Serial clock period in ns: 512 master cycles at 40 MHz
	localparam int SCK_PERIOD_NS   = (SCK_DIVIDER * 1000) / MASTER_CLK_MHZ;
	// Half period in reference cycles, rounded down so the link is never slower
	localparam int SCK_HALF_CYC    = (SCK_PERIOD_NS * REF_CLK_MHZ) / 2000;
	localparam int CNT_W           = 11;
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCK_HALF_CYC - 1);

	// ****************************************
	// Data format
	// ****************************************
	localparam int BYTE_W          = 8;
	localparam int FIFO_DEPTH      = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int EEPROM_KBIT     = 32;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW  = 2'b01,
		ST_HIGH = 2'b10
	} port_state_t;
endpackage

//--- rtl/byte_fifo.sv
// Small synchronous FIFO with a registered output stage
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output var  logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             in_ready_nxt, out_valid_nxt;
	logic [WIDTH-1:0] out_data_nxt;
	logic             push, pop, load;

	always_comb begin
		push          = in_valid && in_ready;
		load          = (cnt_r != '0) && (!out_valid || out_ready);
		pop           = load;
		wptr_nxt      = push ? AW'(wptr_r + 1'b1) : wptr_r;
		rptr_nxt      = pop ? AW'(rptr_r + 1'b1) : rptr_r;
		cnt_nxt       = (AW+1)'(cnt_r + push - pop);
		// Output slot counts as space; only the array is limited here
		in_ready_nxt  = cnt_nxt < (AW+1)'(DEPTH);
		out_data_nxt  = load ? mem_r[rptr_r] : out_data;
		out_valid_nxt = load ? 1'b1 : (out_valid && !out_ready);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r    <= '0;
			rptr_r    <= '0;
			cnt_r     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wptr_r    <= wptr_nxt;
			rptr_r    <= rptr_nxt;
			cnt_r     <= cnt_nxt;
			in_ready  <= in_ready_nxt;
			out_valid <= out_valid_nxt;
			out_data  <= out_data_nxt;
		end
	end

	// Storage needs no reset
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wptr_r] <= in_data;
		end
	end
endmodule
`default_nettype wire

//--- rtl/serial_eeprom_port.sv
// Two-wire serial EEPROM port: byte shift engine with read data FIFO
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_port (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// Byte command port
	input  wire logic        cmd_valid,
	output var  logic        cmd_ready,
	input  wire logic        cmd_read,
	input  wire logic [7:0]  cmd_wdata,
	// Read data stream
	output var  logic        rd_valid,
	input  wire logic        rd_ready,
	output var  logic [7:0]  rd_data,
	// EEPROM pins
	output var  logic        eeprom_serial_clock,
	input  wire logic        eeprom_serial_data_line_i,
	output var  logic        eeprom_serial_data_line_o,
	output var  logic        eeprom_serial_data_line_oe,
	// Status
	output var  logic        busy
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_r, rst_n;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ****************************************
	// Shift engine
	// ****************************************
	eeprom_port_pkg::port_state_t   state_r, state_nxt;
	logic [eeprom_port_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [2:0]                      bit_r, bit_nxt;
	logic [7:0]                      shift_r, shift_nxt;
	logic                            rd_op_r, rd_op_nxt;
	logic                            sck_nxt, oe_nxt, ready_nxt, busy_nxt;
	logic                            push_r, push_nxt;
	logic                            take, fifo_in_ready, sample_en;

	assign take = cmd_valid && cmd_ready;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = eeprom_port_pkg::CNT_W'(cnt_r + 1'b1);
		bit_nxt   = bit_r;
		shift_nxt = shift_r;
		rd_op_nxt = rd_op_r;
		sck_nxt   = eeprom_serial_clock;
		// Line keeps its level between bytes so no edge appears while clock is high
		oe_nxt    = eeprom_serial_data_line_oe;
		push_nxt  = 1'b0;
		sample_en = 1'b0;
		case (state_r)
			eeprom_port_pkg::ST_IDLE: begin
				cnt_nxt = '0;
				sck_nxt = 1'b1;
				if (take) begin
					state_nxt = eeprom_port_pkg::ST_LOW;
					sck_nxt   = 1'b0;
					bit_nxt   = '0;
					rd_op_nxt = cmd_read;
					shift_nxt = cmd_wdata;
				end
			end
			eeprom_port_pkg::ST_LOW: begin
				if (cnt_r == '0) begin
					// One cycle after the falling edge
					oe_nxt = rd_op_r ? 1'b0 : !shift_r[7];
				end
				if (cnt_r == eeprom_port_pkg::HALF_LAST) begin
					state_nxt = eeprom_port_pkg::ST_HIGH;
					sck_nxt   = 1'b1;
					cnt_nxt   = '0;
				end
			end
			eeprom_port_pkg::ST_HIGH: begin
				if (cnt_r == '0) begin
					sample_en = 1'b1;
					// Read captures the line; write just moves to the next bit
					shift_nxt = {shift_r[6:0], rd_op_r ? eeprom_serial_data_line_i : 1'b0};
				end
				if (cnt_r == eeprom_port_pkg::HALF_LAST) begin
					cnt_nxt = '0;
					if (bit_r == eeprom_port_pkg::BIT_LAST) begin
						state_nxt = eeprom_port_pkg::ST_IDLE;
						push_nxt  = rd_op_r;
					end else begin
						state_nxt = eeprom_port_pkg::ST_LOW;
						sck_nxt   = 1'b0;
						bit_nxt   = 3'(bit_r + 1'b1);
					end
				end
			end
			default: begin
				state_nxt = eeprom_port_pkg::ST_IDLE;
				sck_nxt   = 1'b1;
			end
		endcase
		// Ready only after a settled idle cycle, so the FIFO space seen is current
		// A pending push has not reached the FIFO space flag yet, so hold off one more cycle
		ready_nxt = (state_r == eeprom_port_pkg::ST_IDLE) && !take && !push_r && fifo_in_ready;
		busy_nxt  = state_nxt != eeprom_port_pkg::ST_IDLE;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r                    <= eeprom_port_pkg::ST_IDLE;
			cnt_r                      <= '0;
			bit_r                      <= '0;
			shift_r                    <= '0;
			rd_op_r                    <= 1'b0;
			push_r                     <= 1'b0;
			cmd_ready                  <= 1'b0;
			busy                       <= 1'b0;
			eeprom_serial_clock        <= 1'b1;
			eeprom_serial_data_line_oe <= 1'b0;
			eeprom_serial_data_line_o  <= 1'b0;
		end else begin
			state_r                    <= state_nxt;
			cnt_r                      <= cnt_nxt;
			bit_r                      <= bit_nxt;
			shift_r                    <= shift_nxt;
			rd_op_r                    <= rd_op_nxt;
			push_r                     <= push_nxt;
			cmd_ready                  <= ready_nxt;
			busy                       <= busy_nxt;
			eeprom_serial_clock        <= sck_nxt;
			eeprom_serial_data_line_oe <= oe_nxt;
			eeprom_serial_data_line_o  <= 1'b0;
		end
	end

	// ****************************************
	// Read data buffer
	// ****************************************
	byte_fifo #(
		.WIDTH (eeprom_port_pkg::BYTE_W),
		.DEPTH (eeprom_port_pkg::FIFO_DEPTH)
	) u_rd_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (push_r),
		.in_ready  (fifo_in_ready),
		.in_data   (shift_r),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence fall_s;
		$fell(eeprom_serial_clock);
	endsequence
	sequence rise_s;
		$rose(eeprom_serial_clock);
	endsequence

	idle_clock_high_a: assert property (state_r == eeprom_port_pkg::ST_IDLE |-> eeprom_serial_clock)
		else $error("serial clock low while idle");
	half_period_a: assert property (rise_s |-> $past(cnt_r) == eeprom_port_pkg::HALF_LAST)
		else $error("serial clock low phase has wrong length");
	sda_after_fall_a: assert property ($changed(eeprom_serial_data_line_oe) |->
		!eeprom_serial_clock && $past(eeprom_serial_clock, 2))
		else $error("data line moved other than just after a falling edge");
	sample_after_rise_a: assert property (sample_en |-> rise_s)
		else $error("data sampled other than just after a rising edge");
	read_release_a: assert property (fall_s ##1 rd_op_r |=> !eeprom_serial_data_line_oe)
		else $error("data line driven during a read");
	drive_low_only_a: assert property (eeprom_serial_data_line_oe |-> !eeprom_serial_data_line_o)
		else $error("data line driven high");
	byte_push_a: assert property (push_r |-> rd_op_r && $past(bit_r) == eeprom_port_pkg::BIT_LAST
		&& eeprom_serial_clock)
		else $error("read byte pushed before eighth bit");
	cmd_start_a: assert property (take |=> state_r == eeprom_port_pkg::ST_LOW && !eeprom_serial_clock)
		else $error("accepted command did not start a transfer");
endmodule
`default_nettype wire

//--- tb/eeprom_model.sv
// Behavioural serial EEPROM facing the port
`timescale 1ns/100ps
`default_nettype none
module eeprom_model (
	// Pins
	input  wire logic       sck,
	input  wire logic       line,
	output var  logic       pull_low,
	// Bench control
	input  wire logic       send_en,
	input  wire logic [7:0] send_byte,
	output var  logic [7:0] got_r
);
	logic [2:0] idx_r = 3'h7;
	initial pull_low = 1'b0;
	// Each bit changes at the falling clock edge, MSB first
	always @(negedge sck) begin
		pull_low <= send_en & ~send_byte[idx_r];
		idx_r    <= idx_r - 3'h1;
	end
	// Release long after the port sampled the last bit
	always @(posedge sck) begin
		got_r <= {got_r[6:0], line};
		if (idx_r == 3'h7) pull_low <= #100 1'b0;
	end
endmodule
`default_nettype wire

//--- tb/serial_eeprom_port_bench.sv
// Self-checking bench for the serial EEPROM port
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_port_bench;
	logic       ref_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
	logic       rd_ready = 1'b0, send_en = 1'b0;
	logic [7:0] cmd_wdata = 8'h00, send_byte = 8'h00, wr_b, rd_a, rd_b;
	wire  logic cmd_ready, rd_valid, sck, oe, o, busy, pull_low, line;
	wire  logic [7:0] rd_data, got;
	integer     seed = 32'h27E8, errors = 0, n_tests = 0;
	time        t_fall = 0;

	always #2 ref_clk = ~ref_clk;
	// Open drain wire with pull-up
	assign line = !((oe && !o) || pull_low);

	serial_eeprom_port serial_eeprom_port_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .eeprom_serial_clock(sck),
		.eeprom_serial_data_line_i(line), .eeprom_serial_data_line_o(o),
		.eeprom_serial_data_line_oe(oe), .busy(busy));
	eeprom_model eeprom_model_inst (.sck(sck), .line(line), .pull_low(pull_low),
		.send_en(send_en), .send_byte(send_byte), .got_r(got));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Half serial clock period in 4 ns bench cycles
	function automatic logic [31:0] half_cycles(input int div, input int mhz);
		return 32'((div * 1000 / mhz) / 2 / 4);
	endfunction

	task conclude;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Busy rises at the same edge that takes the command; still wait at least three edges first
	task automatic issue(input logic r, input logic [7:0] d);
		integer k;
		cmd_valid <= 1'b1;
		cmd_read  <= r;
		cmd_wdata <= d;
		k = 0;
		do begin @(posedge ref_clk); k++; end while (cmd_ready !== 1'b1 && k < 50);
		check(32'(cmd_ready), 32'h1);
		cmd_valid <= 1'b0;
		k = 0;
		do begin @(posedge ref_clk); k++; end while ((k < 3 || busy === 1'b1) && k < 30000);
		check(32'(busy), 32'h0);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic pop(input logic [7:0] e);
		check(32'(rd_valid), 32'h1);
		check(32'(rd_data), 32'(e));
		rd_ready <= 1'b1;
		@(posedge ref_clk);
		rd_ready <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// ****************************************
	// Wire monitors
	// ****************************************
	always @(negedge sck) t_fall = $time;
	always @(posedge sck) if (busy === 1'b1) check(32'(($time - t_fall) / 4), half_cycles(512, 40));
	always @(sck) if (arst_n === 1'b1) #1 check(32'(busy), 32'h1);
	always @(oe) if (busy === 1'b1 && sck === 1'b1) check(32'h1, 32'h0);

	initial begin
		repeat (95000) @(posedge ref_clk);
		errors++;
		conclude;
	end

	initial begin
		wr_b = 8'($random(seed));
		rd_a = 8'h01;
		rd_b = 8'($random(seed));
		repeat (4) @(posedge ref_clk);
		check(32'({sck, oe, busy, cmd_ready}), 32'h8);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		issue(1'b0, wr_b);
		check(32'(got), 32'(wr_b));
		send_en   <= 1'b1;
		send_byte <= rd_a;
		issue(1'b1, 8'h00);
		send_byte <= rd_b;
		issue(1'b1, 8'h00);
		send_en   <= 1'b0;
		pop(rd_a);
		pop(rd_b);
		check(32'(rd_valid), 32'h0);
		conclude;
	end
endmodule
`default_nettype wire
